// ---- design/afl_map.svh ----
/*
 * Offsets, field positions and reset values of the alert and flag logic.
 * Assumes inclusion by bare name from the design module only.
 */
`ifndef AFL_MAP_SVH
`define AFL_MAP_SVH

// ----------------------------------------------------------------------------
// register pointers
// ----------------------------------------------------------------------------
`define AFL_ADDR_CONFIG       8'h00
`define AFL_ADDR_MASK         8'h06
`define AFL_ADDR_LIMIT        8'h07

// ----------------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------------
`define AFL_BIT_SHUNT_OVER    15
`define AFL_BIT_SHUNT_UNDER   14
`define AFL_BIT_BUS_OVER      13
`define AFL_BIT_BUS_UNDER     12
`define AFL_BIT_POWER_OVER    11
`define AFL_BIT_READY_ALERT   10
`define AFL_BIT_FUNC_FLAG     4
`define AFL_BIT_DONE_FLAG     3
`define AFL_BIT_OVF_FLAG      2
`define AFL_BIT_POLARITY      1
`define AFL_BIT_LATCH         0

// ----------------------------------------------------------------------------
// reset values and mode codes
// ----------------------------------------------------------------------------
`define AFL_RST_CTRL          6'h00
`define AFL_RST_LIMIT         16'h0000
`define AFL_MODE_POWER_DOWN   3'h0
`define AFL_MODE_DISABLE      3'h4

`endif

// ---- design/afl_pkg.sv ----
/*
 * Types of the alert and flag logic.
 * Assumes nothing beyond its map header.
 */
package afl_pkg;

	// ------------------------------------------------------------------------
	// measurement results arriving from the conversion engine
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] shunt;
		logic [15:0] bus;
		logic [15:0] power;
	} afl_result_s;

	// ------------------------------------------------------------------------
	// register access request
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} afl_access_s;

	// ------------------------------------------------------------------------
	// selected limit function
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		AFL_FN_NONE,
		AFL_FN_SHUNT_OVER,
		AFL_FN_SHUNT_UNDER,
		AFL_FN_BUS_OVER,
		AFL_FN_BUS_UNDER,
		AFL_FN_POWER_OVER
	} afl_func_e;

endpackage

// ---- design/afl_alert_flags.sv ----
/*
 * Alert pin and status flag logic of a current, voltage and power monitor.
 * Assumes the serial interface delivers one-cycle decoded register strobes
 * and the conversion engine one-cycle done/overflow strobes, all on clock_i.
 */
`timescale 1ns/1ps
`include "afl_map.svh"

module afl_alert_flags (
	// clock and reset
	input  wire logic                 clock_i,
	input  wire logic                 rst_b_i,
	// register access from the serial interface
	input  wire afl_pkg::afl_access_s access_i,
	input  wire logic [2:0]           cfg_mode_i,
	input  wire logic                 single_shot_i,
	output logic      [15:0]          rdata_o,
	// conversion engine
	input  wire logic                 cycle_done_i,
	input  wire logic                 math_overflow_i,
	input  wire afl_pkg::afl_result_s result_i,
	output afl_pkg::afl_result_s      result_o,
	// open-collector alert pin
	output logic                      alert_o,
	output logic                      alert_oe_o
);

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	logic [5:0]           enables;
	logic [5:0]           next_enables;
	logic                 output_polarity_select;
	logic                 next_output_polarity_select;
	logic                 latch_select;
	logic                 next_latch_select;
	logic                 function_alert_flag;
	logic                 next_function_alert_flag;
	logic                 conversion_done_flag;
	logic                 next_conversion_done_flag;
	logic                 math_overflow_flag;
	logic                 next_math_overflow_flag;
	logic [15:0]          limit_value_bits;
	logic [15:0]          next_limit_value_bits;
	afl_pkg::afl_result_s results;
	afl_pkg::afl_result_s next_results;
	logic [15:0]          next_rdata;
	logic                 alert_active;
	logic                 next_alert_active;
	afl_pkg::afl_func_e   func;
	logic                 violation;
	logic                 mask_wr;
	logic                 mask_rd;
	logic                 cfg_wr;

	assign mask_wr = access_i.wr && (access_i.addr == `AFL_ADDR_MASK);
	assign mask_rd = access_i.rd && (access_i.addr == `AFL_ADDR_MASK);
	assign cfg_wr  = access_i.wr && (access_i.addr == `AFL_ADDR_CONFIG);

	// ------------------------------------------------------------------------
	// limit function select and compare
	// ------------------------------------------------------------------------
	function automatic afl_pkg::afl_func_e pick(input logic [5:0] en);
		// en[5] is bit 15 down to en[1] bit 11; highest wins
		if (en[5]) begin
			pick = afl_pkg::AFL_FN_SHUNT_OVER;
		end else if (en[4]) begin
			pick = afl_pkg::AFL_FN_SHUNT_UNDER;
		end else if (en[3]) begin
			pick = afl_pkg::AFL_FN_BUS_OVER;
		end else if (en[2]) begin
			pick = afl_pkg::AFL_FN_BUS_UNDER;
		end else if (en[1]) begin
			pick = afl_pkg::AFL_FN_POWER_OVER;
		end else begin
			pick = afl_pkg::AFL_FN_NONE;
		end
	endfunction

	function automatic logic over(input logic [15:0] v, input logic [15:0] lim);
		// shunt and bus results are two's complement
		over = $signed(v) > $signed(lim);
	endfunction

	assign func = pick(enables);

	always_comb begin
		case (func)
			afl_pkg::AFL_FN_SHUNT_OVER:  violation = over(result_i.shunt, limit_value_bits);
			afl_pkg::AFL_FN_SHUNT_UNDER: violation = over(limit_value_bits, result_i.shunt);
			afl_pkg::AFL_FN_BUS_OVER:    violation = over(result_i.bus, limit_value_bits);
			afl_pkg::AFL_FN_BUS_UNDER:   violation = over(limit_value_bits, result_i.bus);
			afl_pkg::AFL_FN_POWER_OVER:  violation = result_i.power > limit_value_bits;
			default:                     violation = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb begin
		next_enables                = enables;
		next_output_polarity_select = output_polarity_select;
		next_latch_select           = latch_select;
		next_limit_value_bits       = limit_value_bits;
		next_results                = results;
		next_function_alert_flag    = function_alert_flag;
		next_conversion_done_flag   = conversion_done_flag;
		next_math_overflow_flag     = math_overflow_flag;
		next_alert_active           = alert_active;
		if (mask_wr) begin
			next_enables                = access_i.wdata[`AFL_BIT_SHUNT_OVER:`AFL_BIT_READY_ALERT];
			next_output_polarity_select = access_i.wdata[`AFL_BIT_POLARITY];
			next_latch_select           = access_i.wdata[`AFL_BIT_LATCH];
		end
		if (access_i.wr && access_i.addr == `AFL_ADDR_LIMIT) begin
			next_limit_value_bits = access_i.wdata;
		end
		// read clears first, so a same-cycle event below still wins
		if (mask_rd) begin
			if (latch_select) begin
				next_function_alert_flag = 1'b0;
				next_math_overflow_flag  = 1'b0;
				next_alert_active        = 1'b0;
			end
			if (single_shot_i) begin
				next_conversion_done_flag = 1'b0;
			end
		end
		if (cfg_wr && single_shot_i && cfg_mode_i != `AFL_MODE_POWER_DOWN
			&& cfg_mode_i != `AFL_MODE_DISABLE) begin
			next_conversion_done_flag = 1'b0;
		end
		if (cycle_done_i) begin
			next_results              = result_i;
			next_conversion_done_flag = 1'b1;
			if (violation) begin
				next_function_alert_flag = 1'b1;
			end else if (!latch_select) begin
				next_function_alert_flag = 1'b0;
			end
			if (latch_select) begin
				// builds on the read clear above, so a same-cycle read is not lost
				next_alert_active = next_alert_active | violation | enables[0];
			end else begin
				next_alert_active = violation | enables[0];
			end
			if (!latch_select && !math_overflow_i) begin
				next_math_overflow_flag = 1'b0;
			end
		end
		if (math_overflow_i) begin
			next_math_overflow_flag = 1'b1;
		end
		next_rdata = 16'h0000;
		if (access_i.addr == `AFL_ADDR_MASK) begin
			next_rdata = {enables, 5'h00, function_alert_flag, conversion_done_flag,
				math_overflow_flag, output_polarity_select, latch_select};
		end else if (access_i.addr == `AFL_ADDR_LIMIT) begin
			next_rdata = limit_value_bits;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			enables                <= `AFL_RST_CTRL;
			output_polarity_select <= 1'b0;
			latch_select           <= 1'b0;
			limit_value_bits       <= `AFL_RST_LIMIT;
			results                <= '0;
			function_alert_flag    <= 1'b0;
			conversion_done_flag   <= 1'b0;
			math_overflow_flag     <= 1'b0;
			alert_active           <= 1'b0;
			rdata_o                <= 16'h0000;
		end else begin
			enables                <= next_enables;
			output_polarity_select <= next_output_polarity_select;
			latch_select           <= next_latch_select;
			limit_value_bits       <= next_limit_value_bits;
			results                <= next_results;
			function_alert_flag    <= next_function_alert_flag;
			conversion_done_flag   <= next_conversion_done_flag;
			math_overflow_flag     <= next_math_overflow_flag;
			alert_active           <= next_alert_active;
			rdata_o                <= next_rdata;
		end
	end

	// ------------------------------------------------------------------------
	// open-collector pin: only ever pulls low, enable marks the pull
	// ------------------------------------------------------------------------
	assign result_o   = results;
	assign alert_o    = 1'b0;
	assign alert_oe_o = alert_active ^ output_polarity_select;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	sequence done_with_fault;
		cycle_done_i && violation;
	endsequence

	// a fault puts the pin at its active level: pulled low for polarity zero, released for one
	pin_polarity_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		done_with_fault && !mask_wr |=> alert_oe_o != output_polarity_select)
		else $error("alert pin level does not follow polarity");
	fault_sets_flag_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		done_with_fault |=> function_alert_flag && alert_active)
		else $error("fault did not raise flag and alert");
	clean_clears_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		cycle_done_i && !violation && !latch_select |=> !function_alert_flag)
		else $error("transparent flag not cleared by clean result");
	latch_holds_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		latch_select && !mask_wr && alert_active && !mask_rd |=> alert_active)
		else $error("latched alert dropped without read");
	done_sets_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		cycle_done_i |=> conversion_done_flag)
		else $error("done flag not set after cycle");
	read_clears_done_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		mask_rd && single_shot_i && !cycle_done_i |=> !conversion_done_flag)
		else $error("mask read did not clear done flag");
	overflow_sets_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		math_overflow_i |=> math_overflow_flag)
		else $error("overflow flag not set");
	result_held_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		cycle_done_i |=> result_o == $past(result_i))
		else $error("result not captured");
	ready_alert_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		cycle_done_i && enables[0] |=> alert_active)
		else $error("ready alert not raised");

endmodule // afl_alert_flags

// ---- testbench/afl_host_model.sv ----
/*
 * Host side of the alert pin: pull-up and open-collector wire resolution.
 * Assumes the alert block drives alert_o and alert_oe_o on one clock.
 */
`timescale 1ns/1ps

module afl_host_model (
	// pin drive from the device
	input  wire logic alert_o,
	input  wire logic alert_oe_o,
	// level the host sees on the wire
	output logic      pin_level_o
);
	// released pin floats up through the pull-up, never keeps the old value
	assign pin_level_o = alert_oe_o ? alert_o : 1'b1;
endmodule // afl_host_model

// ---- testbench/testbench.sv ----
/*
 * Self-checking bench of the alert and flag logic: register reads and writes,
 * conversions with chosen results, and the alert pin seen through the host.
 * Assumes the design's one-cycle strobes and registered read data.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
	logic                 clock_i;
	logic                 rst_b_i;
	logic                 done_p;
	logic                 ovf_p;
	logic                 ss;
	logic                 pin;
	logic                 alert;
	logic                 oe;
	logic [2:0]           mode;
	logic [5:0]           en;
	logic [15:0]          rdata;
	afl_pkg::afl_access_s acc;
	afl_pkg::afl_result_s res;
	afl_pkg::afl_result_s res_o;
	int                   errors;
	int                   check_count;
	int                   cycles;
	logic [15:0]          vv [5] = '{16'h7D01, 16'h7CFF, 16'h7D01, 16'h7CFF, 16'h7D01};
	logic [2:0]           cm [3] = '{3'h0, 3'h4, 3'h1};
	logic                 cd [3] = '{1'b1, 1'b1, 1'b0};

	afl_alert_flags DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .access_i(acc),
		.cfg_mode_i(mode), .single_shot_i(ss), .rdata_o(rdata), .cycle_done_i(done_p),
		.math_overflow_i(ovf_p), .result_i(res), .result_o(res_o), .alert_o(alert),
		.alert_oe_o(oe));
	afl_host_model host (.alert_o(alert), .alert_oe_o(oe), .pin_level_o(pin));

	// ------------------------------------------------------------------------
	// access and conversion tasks
	// ------------------------------------------------------------------------
	function automatic logic [15:0] mw(input logic [5:0] e, input logic f, d, o, pl, lt);
		return {e, 5'h00, f, d, o, pl, lt};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [2:0] m);
		@(posedge clock_i);
		acc <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		mode <= m;
		@(posedge clock_i);
		acc.wr <= 1'b0;
	endtask

	// read data is sampled at the edge that takes the strobe, so pre-clear flags show
	task automatic chkrd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock_i);
		acc <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clock_i);
		acc.rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask

	task automatic conv(input logic [15:0] s, b, p);
		@(posedge clock_i);
		done_p <= 1'b1;
		res <= '{shunt: s, bus: b, power: p};
		@(posedge clock_i);
		done_p <= 1'b0;
		#1 `CHK(res_o, {s, b, p})
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	// whole run is under two hundred cycles
	initial begin
		cycles = 0;
		forever @(posedge clock_i) begin
			cycles++;
			if (cycles == 3000) begin
				errors++;
				tally_and_finish;
			end
		end
	end

	// ------------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------------
	initial begin
		rst_b_i = 1'b0; done_p = 1'b0; ovf_p = 1'b0; ss = 1'b0; mode = 3'h0;
		acc = '0; res = '0; en = 6'h00; errors = 0; check_count = 0;
		repeat (20) @(posedge clock_i);
		rst_b_i <= 1'b1;
		chkrd(8'h06, 16'h0000);
		chkrd(8'h05, 16'h0000);
		`CHK(pin, 1'b1)
		wr(8'h07, 16'h7D00, 3'h0);
		chkrd(8'h07, 16'h7D00);
		$display("test reset and limit done");
		for (int i = 0; i < 5; i++) begin
			en = 6'h20 >> i;
			wr(8'h06, {en, 10'h000}, 3'h0);
			conv(i < 2 ? vv[i] : 16'h7D00, (i == 2 || i == 3) ? vv[i] : 16'h7D00,
				i == 4 ? vv[i] : 16'h7D00);
			`CHK(pin, 1'b0)
			chkrd(8'h06, mw(en, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
			conv(16'h7D00, 16'h7D00, 16'h7D00);
			`CHK(pin, 1'b1)
			chkrd(8'h06, mw(en, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
		end
		$display("test limit functions done");
		wr(8'h06, 16'h8800, 3'h0);
		conv(16'h7D00, 16'h7D00, 16'hFFFF);
		`CHK(pin, 1'b1)
		conv(16'h7D01, 16'h7D00, 16'h7D00);
		`CHK(pin, 1'b0)
		wr(8'h06, 16'h8002, 3'h0);
		conv(16'h7D01, 16'h7D00, 16'h7D00);
		`CHK(pin, 1'b1)
		conv(16'h7D00, 16'h7D00, 16'h7D00);
		`CHK(pin, 1'b0)
		$display("test priority and polarity done");
		wr(8'h06, 16'h8001, 3'h0);
		conv(16'h7D01, 16'h7D00, 16'h7D00);
		conv(16'h7D00, 16'h7D00, 16'h7D00);
		`CHK(pin, 1'b0)
		chkrd(8'h06, mw(6'h20, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
		`CHK(pin, 1'b1)
		chkrd(8'h06, mw(6'h20, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
		@(posedge clock_i);
		ovf_p <= 1'b1;
		@(posedge clock_i);
		ovf_p <= 1'b0;
		chkrd(8'h06, mw(6'h20, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1));
		chkrd(8'h06, mw(6'h20, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
		$display("test latch and overflow done");
		wr(8'h06, 16'h0000, 3'h0);
		@(posedge clock_i);
		ss <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			conv(16'h7D00, 16'h7D00, 16'h7D00);
			wr(8'h00, 16'h0000, cm[k]);
			chkrd(8'h06, mw(6'h00, 1'b0, cd[k], 1'b0, 1'b0, 1'b0));
			chkrd(8'h06, 16'h0000);
		end
		@(posedge clock_i);
		ss <= 1'b0;
		wr(8'h06, 16'h0400, 3'h0);
		conv(16'h7D00, 16'h7D00, 16'h7D00);
		`CHK(pin, 1'b0)
		chkrd(8'h06, mw(6'h01, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
		$display("test single shot and ready alert done");
		tally_and_finish;
	end
endmodule // testbench
